// ---- hw/pll_frequency_select.v ----
// Configuration and frequency selection logic of a three-synthesizer clock generator.
// Assumes APB access from software, select pins synchronous to pclk, and
// that pclk stands in for every synthesizer's output when dividers are modelled.
`timescale 1ns/1ns
`include "pll_frequency_select_regs.vh"

module pll_frequency_select #(
  parameter QW = 8,
  parameter PW = 11,
  parameter DW = 7
) (
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [7:0]    paddr,
  input  wire [31:0]   pwdata,
  input  wire [3:0]    pstrb,
  output reg  [31:0]   prdata,
  output reg           pready,
  output reg           pslverr,
  input  wire          serial_data_pin,
  input  wire          serial_clock_pin,
  input  wire          select_bit_two,
  input  wire          output_enable_n,
  output reg  [QW-1:0] first_synthesizer_q,
  output reg  [PW-1:0] first_synthesizer_p,
  output reg  [QW-1:0] second_synthesizer_q,
  output reg  [PW-1:0] second_synthesizer_p,
  output reg  [QW-1:0] third_synthesizer_q,
  output reg  [PW-1:0] third_synthesizer_p,
  output reg  [2:0]    synth_run,
  output reg           chip_stop,
  output reg  [4:0]    out_oe,
  output reg           output_a,
  output reg           output_b,
  output reg           output_e,
  output reg  [5:0]    crystal_load_cap,
  output reg  [1:0]    crystal_drive,
  output reg           crystal_cap_bypass
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  // Byte-lane merge, so each factor byte takes effect on its own write
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  strb;
    integer      b;
    begin
      merge = old_v;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b])
          merge[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
  endfunction

  // Output E ratio decode; zero means the output is off
  function [DW-1:0] e_ratio;
    input [1:0] f;
    begin
      case (f)
        `EDIV_BY4: e_ratio = `RATIO_4;
        `EDIV_BY2: e_ratio = `RATIO_2;
        `EDIV_BY3: e_ratio = `RATIO_3;
        default:   e_ratio = {DW{1'b0}};
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  reg  [31:0] ctrl_q;
  reg  [31:0] osc_q;
  reg  [31:0] syn2_q;
  reg  [31:0] syn3_q;
  reg  [31:0] divab_q;
  reg  [31:0] src_q;
  reg  [31:0] tbl_q [0:7];
  reg  [1:0]  strap_q;
  reg         strap_done_q;
  reg  [31:0] rdata_d;
  reg         hit_d;
  wire        setup_ph = psel & ~penable;
  wire        wr_ev    = psel & penable & pready & pwrite;
  wire        in_tbl   = (paddr >= `OFS_TABLE) && (paddr <= `OFS_TABLE_LAST);
  wire [2:0]  tbl_idx  = paddr[4:2];
  integer     r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= `CTRL_RST;
      osc_q   <= `OSC_RST;
      syn2_q  <= `SYN_RST;
      syn3_q  <= `SYN_RST;
      divab_q <= `DIV_RST;
      src_q   <= `SRC_RST;
      for (r = 0; r < 8; r = r + 1)
        tbl_q[r] <= `SYN_RST;
    end else if (wr_ev) begin
      case (paddr)
        `OFS_CTRL:  ctrl_q  <= merge(ctrl_q, pwdata, pstrb);
        `OFS_OSC:   osc_q   <= merge(osc_q, pwdata, pstrb);
        `OFS_SYN2:  syn2_q  <= merge(syn2_q, pwdata, pstrb);
        `OFS_SYN3:  syn3_q  <= merge(syn3_q, pwdata, pstrb);
        `OFS_DIVAB: divab_q <= merge(divab_q, pwdata, pstrb);
        `OFS_SRC:   src_q   <= merge(src_q, pwdata, pstrb);
        default: begin
          if (in_tbl)
            tbl_q[tbl_idx] <= merge(tbl_q[tbl_idx], pwdata, pstrb);
        end
      endcase
    end
  end

  // Strap capture on the first edge after reset; later bus traffic on the
  // shared pins cannot disturb it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q      <= 2'b00;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_q      <= {serial_clock_pin, serial_data_pin};
      strap_done_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Selection and power state
  // --------------------------------------------------------------------------
  wire        susp_mode = ctrl_q[`CTRL_SUSP_MODE];
  wire        susp_act  = susp_mode & ~select_bit_two;
  wire [2:0]  sel_idx   = {susp_mode ? 1'b0 : select_bit_two, strap_q};
  wire [31:0] row       = tbl_q[sel_idx];
  wire        divider_setting_select    = row[`ROW_DIVIDER_SETTING_SELECT];
  wire        pin_low   = ~output_enable_n;
  wire        full_stop = pin_low & ctrl_q[`CTRL_FULL_SD];
  wire [2:0]  syn_en    = ctrl_q[`CTRL_SYN_EN_HI:`CTRL_SYN_EN_LO];
  wire [2:0]  syn_susp  = ctrl_q[`CTRL_SSYN_HI:`CTRL_SSYN_LO];
  wire [4:0]  out_susp  = ctrl_q[`CTRL_SOUT_HI:`CTRL_SOUT_LO];
  wire [2:0]  run_d     = syn_en & ~{3{full_stop}} & ~({3{susp_act}} & syn_susp);
  wire [1:0]  e_field   = ctrl_q[`CTRL_EDIV_HI:`CTRL_EDIV_LO];

  // One shared choice picks setting 0 or 1 for A and B together
  wire [DW-1:0] div_a = divider_setting_select ? divab_q[`DIV_A1_LO +: DW] : divab_q[`DIV_A0_LO +: DW];
  wire [DW-1:0] div_b = divider_setting_select ? divab_q[`DIV_B1_LO +: DW] : divab_q[`DIV_B0_LO +: DW];
  wire [DW-1:0] div_e = e_ratio(e_field);

  // Source of each crosspoint output: 0 reference, 1..3 a synthesizer
  reg  [3:0] src_ok;
  reg  [4:0] oe_d;
  integer    k;
  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      case (src_q[k*2 +: 2])
        2'h0:    src_ok[k] = ~full_stop;
        2'h1:    src_ok[k] = run_d[0];
        2'h2:    src_ok[k] = run_d[1];
        default: src_ok[k] = run_d[2];
      endcase
    end
    // Stopped synthesizer always takes its outputs down with it
    oe_d = {run_d[0], src_ok} & ~({5{susp_act}} & out_susp) & ~{5{pin_low}};
    oe_d[0] = oe_d[0] & (div_a != {DW{1'b0}});
    oe_d[1] = oe_d[1] & (div_b != {DW{1'b0}});
    oe_d[4] = oe_d[4] & (e_field != `EDIV_OFF);
  end

  // --------------------------------------------------------------------------
  // Post-dividers for A, B and E
  // --------------------------------------------------------------------------
  // While running, a new divisor is loaded only at the end of a full period, so a select
  // change never shortens a high or low phase. Costs up to one old period.
  wire [DW-1:0] want [0:2];
  wire [2:0]    div_run;
  wire [2:0]    div_out;
  assign want[0]    = div_a;
  assign want[1]    = div_b;
  assign want[2]    = div_e;
  assign div_run[0] = oe_d[0];
  assign div_run[1] = oe_d[1];
  assign div_run[2] = oe_d[4];

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : post_div
      reg [DW-1:0] cnt_q;
      reg [DW-1:0] cur_q;
      wire         last = (cnt_q + {{(DW-1){1'b0}}, 1'b1} >= cur_q);
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= {DW{1'b0}};
          cur_q <= {DW{1'b0}};
        end else if (!div_run[g]) begin
          cnt_q <= {DW{1'b0}};
          cur_q <= want[g];
        end else if (last) begin
          cnt_q <= {DW{1'b0}};
          cur_q <= want[g];
        end else begin
          cnt_q <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
        end
      end
      // High for the first half period, rounded up for odd ratios
      assign div_out[g] = div_run[g] & ({1'b0, cnt_q} < (({1'b0, cur_q} + 1'b1) >> 1));
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_synthesizer_q  <= {QW{1'b0}};
      first_synthesizer_p  <= {PW{1'b0}};
      second_synthesizer_q <= {QW{1'b0}};
      second_synthesizer_p <= {PW{1'b0}};
      third_synthesizer_q  <= {QW{1'b0}};
      third_synthesizer_p  <= {PW{1'b0}};
      synth_run            <= 3'b000;
      chip_stop            <= 1'b0;
      out_oe               <= 5'b00000;
      output_a             <= 1'b0;
      output_b             <= 1'b0;
      output_e             <= 1'b0;
      crystal_load_cap     <= 6'h00;
      crystal_drive        <= 2'b00;
      crystal_cap_bypass   <= 1'b0;
    end else begin
      first_synthesizer_q  <= row[`Q_HI:0];
      first_synthesizer_p  <= row[`P_HI:`P_LO];
      second_synthesizer_q <= syn2_q[`Q_HI:0];
      second_synthesizer_p <= syn2_q[`P_HI:`P_LO];
      third_synthesizer_q  <= syn3_q[`Q_HI:0];
      third_synthesizer_p  <= syn3_q[`P_HI:`P_LO];
      synth_run            <= run_d;
      chip_stop            <= full_stop;
      out_oe               <= oe_d;
      output_a             <= div_out[0];
      output_b             <= div_out[1];
      output_e             <= div_out[2];
      crystal_load_cap     <= osc_q[`OSC_CAP_HI:0];
      crystal_drive        <= ctrl_q[`CTRL_DRV_HI:`CTRL_DRV_LO];
      crystal_cap_bypass   <= ctrl_q[`CTRL_BYPASS];
    end
  end

  // --------------------------------------------------------------------------
  // APB read path and response
  // --------------------------------------------------------------------------
  // Decoded in the setup cycle so every bus output comes from a flip-flop;
  // the access phase therefore always lasts exactly one cycle
  always @* begin
    rdata_d = 32'h0000_0000;
    hit_d   = 1'b1;
    case (paddr)
      `OFS_CTRL:   rdata_d = ctrl_q;
      `OFS_OSC:    rdata_d = osc_q;
      `OFS_SYN2:   rdata_d = syn2_q;
      `OFS_SYN3:   rdata_d = syn3_q;
      `OFS_DIVAB:  rdata_d = divab_q;
      `OFS_SRC:    rdata_d = src_q;
      `OFS_STATUS: rdata_d = {18'h00000, oe_d, run_d, full_stop,
                              susp_act, divider_setting_select, sel_idx};
      default: begin
        if (in_tbl && paddr[1:0] == 2'b00)
          rdata_d = tbl_q[tbl_idx];
        else
          hit_d = 1'b0;
      end
    endcase
    if (paddr[1:0] != 2'b00)
      hit_d = 1'b0;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
      pready  <= 1'b1;
      pslverr <= ~hit_d;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule // pll_frequency_select

// ---- hw/pll_frequency_select_regs.vh ----
// Register offsets, field positions and reset values of the clock select block.
// Assumes a 32-bit APB bus with byte addresses and one aligned word per register.
`ifndef PLL_FREQUENCY_SELECT_REGS_VH
`define PLL_FREQUENCY_SELECT_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_OSC         8'h04
`define OFS_SYN2        8'h08
`define OFS_SYN3        8'h0C
`define OFS_DIVAB       8'h10
`define OFS_SRC         8'h14
`define OFS_STATUS      8'h18
`define OFS_TABLE       8'h20
`define OFS_TABLE_LAST  8'h3C

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define CTRL_FULL_SD    0
`define CTRL_SUSP_MODE  1
`define CTRL_SYN_EN_LO  2
`define CTRL_SYN_EN_HI  4
`define CTRL_SOUT_LO    8
`define CTRL_SOUT_HI    12
`define CTRL_SSYN_LO    13
`define CTRL_SSYN_HI    15
`define CTRL_EDIV_LO    16
`define CTRL_EDIV_HI    17
`define CTRL_DRV_LO     20
`define CTRL_DRV_HI     21
`define CTRL_BYPASS     24
`define CTRL_RST        32'h0001_001D

// ----------------------------------------------------------------------------
// Oscillator, factor, divider and source fields
// ----------------------------------------------------------------------------
`define OSC_CAP_HI      5
`define OSC_RST         32'h0000_0018
`define Q_HI            7
`define P_LO            8
`define P_HI            18
`define ROW_DIVIDER_SETTING_SELECT      20
`define SYN_RST         32'h0000_0801
`define DIV_A0_LO       0
`define DIV_A1_LO       8
`define DIV_B0_LO       16
`define DIV_B1_LO       24
`define DIV_RST         32'h0404_0202
`define SRC_RST         32'h0000_0055

// ----------------------------------------------------------------------------
// Output E divider field codes and ratios
// ----------------------------------------------------------------------------
`define EDIV_OFF        2'b00
`define EDIV_BY4        2'b01
`define EDIV_BY2        2'b10
`define EDIV_BY3        2'b11
`define RATIO_4         7'h04
`define RATIO_2         7'h02
`define RATIO_3         7'h03

`endif

// ---- verification/host_pins.sv ----
// Host model of the strap, select and enable pins.
// Assumes the bench asks for levels; pins move just after pclk rises.
`timescale 1ns/1ns
module host_pins (
  input  wire       pclk,
  input  wire [1:0] strap,
  input  wire       traffic,
  input  wire       s2_level,
  input  wire       oe_level_n,
  output reg        serial_data_pin = 1'b0,
  output reg        serial_clock_pin = 1'b0,
  output reg        select_bit_two = 1'b0,
  output reg        output_enable_n = 1'b1
);
  // --------------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------------
  // Bus traffic changes both shared pins every cycle, so a late capture shows
  always @(posedge pclk) begin
    serial_data_pin  <= traffic ? ~serial_data_pin : strap[0];
    serial_clock_pin <= traffic ? serial_data_pin : strap[1];
    select_bit_two   <= s2_level;
    output_enable_n  <= oe_level_n;
  end
endmodule // host_pins

// ---- verification/pll_select_sva.sv ----
// Port checker for the clock select block.
// Assumes it is bound onto the design and sees only its ports.
`timescale 1ns/1ns
module pll_select_sva #(
  parameter QW = 8,
  parameter PW = 11
) (
  input wire          pclk,
  input wire          presetn,
  input wire          psel,
  input wire          penable,
  input wire          pwrite,
  input wire          pready,
  input wire          select_bit_two,
  input wire          output_enable_n,
  input wire [QW-1:0] first_synthesizer_q,
  input wire [PW-1:0] first_synthesizer_p,
  input wire [QW-1:0] second_synthesizer_q,
  input wire [PW-1:0] second_synthesizer_p,
  input wire [QW-1:0] third_synthesizer_q,
  input wire [PW-1:0] third_synthesizer_p,
  input wire [2:0]    synth_run,
  input wire          chip_stop,
  input wire [4:0]    out_oe,
  input wire          output_e,
  input wire [5:0]    crystal_load_cap,
  input wire [1:0]    crystal_drive,
  input wire          crystal_cap_bypass
);
  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // Outputs settle over the first edges after reset, so cause checks wait
  reg  [1:0] up_q;
  reg  [1:0] wr_q;
  wire       any_wr = wr_q[0] | wr_q[1];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_q <= 2'h0;
      wr_q <= 2'h0;
    end else begin
      up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
      wr_q <= {wr_q[0], psel & penable & pwrite & pready};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_stop_all: assert property (chip_stop |-> synth_run == 3'h0 && out_oe == 5'h00)
    else $error("full stop left a synthesizer or output on");
  a_stop_cause: assert property (chip_stop |-> $past(!output_enable_n))
    else $error("full stop without a low enable pin");
  a_pin_tristate: assert property (!output_enable_n |=> out_oe == 5'h00)
    else $error("output driven while enable pin low");
  a_first_cause: assert property (up_q == 2'h3
    && $changed({first_synthesizer_q, first_synthesizer_p}) |-> any_wr
    || $past(select_bit_two) != $past(select_bit_two, 2)
    || $past(output_enable_n) != $past(output_enable_n, 2))
    else $error("first synthesizer factors moved without cause");
  a_fixed_synths: assert property (up_q == 2'h3
    && $changed({second_synthesizer_q, second_synthesizer_p, third_synthesizer_q,
    third_synthesizer_p}) |-> any_wr)
    else $error("fixed synthesizer factors moved without a write");
  a_xtal_cfg: assert property (up_q == 2'h3
    && $changed({crystal_load_cap, crystal_drive, crystal_cap_bypass}) |-> any_wr)
    else $error("crystal setting moved without a write");
  a_e_toggle: assert property ($changed(output_e) && out_oe[4]
    |=> ##[0:1] ($changed(output_e) || !out_oe[4]))
    else $error("output E half period longer than two cycles");
  a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not a single pulse after setup");
endmodule // pll_select_sva

bind pll_frequency_select pll_select_sva #(.QW(QW), .PW(PW)) sva_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .select_bit_two(select_bit_two), .output_enable_n(output_enable_n),
  .first_synthesizer_q(first_synthesizer_q), .first_synthesizer_p(first_synthesizer_p),
  .second_synthesizer_q(second_synthesizer_q), .second_synthesizer_p(second_synthesizer_p),
  .third_synthesizer_q(third_synthesizer_q), .third_synthesizer_p(third_synthesizer_p),
  .synth_run(synth_run), .chip_stop(chip_stop), .out_oe(out_oe), .output_e(output_e),
  .crystal_load_cap(crystal_load_cap), .crystal_drive(crystal_drive),
  .crystal_cap_bypass(crystal_cap_bypass)
);

// ---- verification/tb.sv ----
// Self-checking bench: APB registers, select pins and clock outputs.
// Assumes the design header on the include path and the host pin model.
`timescale 1ns/1ns
`include "pll_frequency_select_regs.vh"
module tb;
  typedef struct {logic rd; logic err; logic [31:0] m; logic [31:0] v;} note_t;
  reg          pclk, presetn, psel, penable, pwrite, traffic, s2_level, oe_level_n;
  reg  [7:0]   paddr;
  reg  [31:0]  pwdata;
  reg  [3:0]   pstrb;
  reg  [1:0]   strap;
  wire [31:0]  prdata;
  wire         pready, pslverr, sd, sc, s2, oen, stop, oa, ob, oe, byp;
  wire [7:0]   q1, q2, q3;
  wire [10:0]  p1, p2, p3;
  wire [2:0]   run;
  wire [4:0]   oen_out;
  wire [5:0]   cap;
  wire [1:0]   drv;
  note_t       notes[$];
  note_t       nt;
  int          fails, n_checks, n;
  logic [7:0]  rq[8];
  logic [10:0] rp[8];
  logic [31:0] w, v;
  int          ediv[4] = '{0, 4, 2, 3};

  pll_frequency_select dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_data_pin(sd), .serial_clock_pin(sc), .select_bit_two(s2),
    .output_enable_n(oen), .first_synthesizer_q(q1), .first_synthesizer_p(p1),
    .second_synthesizer_q(q2), .second_synthesizer_p(p2), .third_synthesizer_q(q3),
    .third_synthesizer_p(p3), .synth_run(run), .chip_stop(stop), .out_oe(oen_out),
    .output_a(oa), .output_b(ob), .output_e(oe), .crystal_load_cap(cap),
    .crystal_drive(drv), .crystal_cap_bypass(byp));
  host_pins pins_u (.pclk(pclk), .strap(strap), .traffic(traffic), .s2_level(s2_level),
    .oe_level_n(oe_level_n), .serial_data_pin(sd), .serial_clock_pin(sc),
    .select_bit_two(s2), .output_enable_n(oen));

  // --------------------------------------------------------------------------
  // Tasks and result monitor
  // --------------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic e);
    notes.push_back('{1'b1, e, m, x});
    apb(1'b0, a, 32'h0, 4'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic e);
    notes.push_back('{1'b0, e, 32'h0, 32'h0});
    apb(1'b1, a, d, s);
  endtask
  function logic sig(input int k);
    sig = (k == 0) ? oa : (k == 1) ? ob : oe;
  endfunction
  // Period from one rising edge to the next; a stopped clock ends by the bound
  task per(input int k);
    logic p;
    p = 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge pclk);
      if (p === 1'b0 && sig(k) === 1'b1) break;
      p = sig(k);
    end
    p = 1'b1;
    repeat (300) begin
      @(posedge pclk);
      n++;
      if (p === 1'b0 && sig(k) === 1'b1) break;
      p = sig(k);
    end
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) chk(32'h1, 32'h0);
      else begin
        nt = notes.pop_front();
        chk({31'h0, pslverr}, {31'h0, nt.err});
        if (nt.rd) chk(prdata & nt.m, nt.v);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    give_verdict();
  end

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    void'($urandom(9856));
    {psel, penable, pwrite, traffic, s2_level} = 5'h00;
    oe_level_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    strap = 2'($urandom());
    presetn = 1'b0;
    wt(3);
    presetn <= 1'b1;
    rd(`OFS_CTRL, 32'hFFFFFFFF, `CTRL_RST, 1'b0);
    rd(`OFS_OSC, 32'hFFFFFFFF, `OSC_RST, 1'b0);
    rd(`OFS_SYN2, 32'hFFFFFFFF, `SYN_RST, 1'b0);
    rd(`OFS_SYN3, 32'hFFFFFFFF, `SYN_RST, 1'b0);
    rd(`OFS_DIVAB, 32'hFFFFFFFF, `DIV_RST, 1'b0);
    rd(`OFS_SRC, 32'hFFFFFFFF, `SRC_RST, 1'b0);
    rd(8'h1C, 32'hFFFFFFFF, 32'h0, 1'b1);
    rd(8'h02, 32'hFFFFFFFF, 32'h0, 1'b1);
    wr(8'h1C, 32'hFFFFFFFF, 4'hF, 1'b1);
    rd(`OFS_STATUS, 32'h7, {30'h0, strap}, 1'b0);
    traffic <= 1'b1;
    wt(9);
    rd(`OFS_STATUS, 32'h7, {30'h0, strap}, 1'b0);
    traffic <= 1'b0;
    $display("test 1 done");
    for (int r = 0; r < 8; r++) begin
      rq[r] = 8'($urandom());
      rp[r] = 11'($urandom());
      wr(`OFS_TABLE + 8'(4 * r), {11'h0, r[2], 1'b0, rp[r], rq[r]}, 4'hF, 1'b0);
    end
    v = $urandom();
    wr(`OFS_SYN2, v, 4'hF, 1'b0);
    wr(`OFS_SYN3, ~v, 4'hF, 1'b0);
    for (int s = 0; s < 2; s++) begin
      s2_level <= s[0];
      wt(4);
      chk({13'h0, q1, p1}, {13'h0, rq[{s[0], strap}], rp[{s[0], strap}]});
      chk({13'h0, q2, p2}, {13'h0, v[7:0], v[18:8]});
      chk({13'h0, q3, p3}, {13'h0, ~v[7:0], ~v[18:8]});
    end
    w = $urandom();
    wr(`OFS_TABLE + {3'h0, 1'b1, strap, 2'h0}, {11'h0, 1'b1, 1'b0, w[18:0]}, 4'hF, 1'b0);
    wt(3);
    chk({13'h0, q1, p1}, {13'h0, w[7:0], w[18:8]});
    $display("test 2 done");
    wr(`OFS_DIVAB, 32'h07060503, 4'hF, 1'b0);
    for (int s = 0; s < 2; s++) begin
      s2_level <= s[0];
      per(0);
      per(0);
      chk(n, s ? 5 : 3);
      per(1);
      per(1);
      chk(n, s ? 7 : 6);
    end
    for (int f = 0; f < 4; f++) begin
      wr(`OFS_CTRL, `CTRL_RST & 32'hFFFCFFFF | (32'(f) << 16), 4'hF, 1'b0);
      wt(3);
      chk({31'h0, oen_out[4]}, f != 0);
      if (f != 0) begin
        per(2);
        per(2);
        chk(n, ediv[f]);
      end
    end
    $display("test 3 done");
    w = $urandom();
    wr(`OFS_OSC, {26'h0, w[5:0]}, 4'hF, 1'b0);
    wr(`OFS_CTRL, `CTRL_RST | {7'h0, w[8], 2'h0, w[7:6], 20'h0}, 4'hF, 1'b0);
    wt(3);
    chk({23'h0, cap, drv, byp}, {23'h0, w[5:0], w[7:6], w[8]});
    oe_level_n <= 1'b0;
    wt(4);
    chk({23'h0, stop, run, oen_out}, {23'h0, 1'b1, 3'h0, 5'h00});
    wr(`OFS_CTRL, `CTRL_RST & 32'hFFFFFFFE, 4'hF, 1'b0);
    wt(3);
    chk({23'h0, stop, run, oen_out}, {23'h0, 1'b0, 3'h7, 5'h00});
    oe_level_n <= 1'b1;
    $display("test 4 done");
    s2_level <= 1'b1;
    wr(`OFS_SRC, 32'h00000065, 4'hF, 1'b0);
    wr(`OFS_CTRL, `CTRL_RST | 32'h00004202, 4'hF, 1'b0);
    wt(4);
    chk({24'h0, q1}, {24'h0, rq[{1'b0, strap}]});
    chk({24'h0, run, oen_out}, {24'h0, 3'h7, 5'h1F});
    s2_level <= 1'b0;
    wt(4);
    chk({24'h0, run, oen_out}, {24'h0, 3'h5, 5'h19});
    wr(`OFS_CTRL, `CTRL_RST & 32'hFFFFFFF7, 4'hF, 1'b0);
    w = $urandom();
    wr(`OFS_SYN2, w, 4'h1, 1'b0);
    wt(3);
    chk({12'h0, run[1], q2, p2}, {12'h0, 1'b0, w[7:0], v[18:8]});
    $display("test 5 done");
    give_verdict();
  end
endmodule // tb
